// ---- common/uat_pkg.sv ----
package uat_pkg;
    // ---------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_TX_CTRL   = 8'h00; // transmit_control_register
    localparam logic [7:0] ADDR_RX_CTRL   = 8'h04; // receive_control_register
    localparam logic [7:0] ADDR_TX_BUF    = 8'h08; // transmit_buffer (write only)
    localparam logic [7:0] ADDR_BAUD_LO   = 8'h0c; // baud_divisor_register low byte
    localparam logic [7:0] ADDR_BAUD_HI   = 8'h10; // baud_divisor_register high byte
    localparam logic [7:0] ADDR_INT_CTRL  = 8'h14; // interrupt_control_register
    localparam logic [7:0] ADDR_PIN_DIR   = 8'h18; // pin_direction_bit pair

    // ---------------------------------------------------------------
    // transmit_control_register fields
    // ---------------------------------------------------------------
    localparam int TXC_NINTH_BIT   = 0; // ninth_transmit_bit
    localparam int TXC_SHIFT_EMPTY = 1; // shift_register_empty (read only)
    localparam int TXC_STOP2       = 2; // two stop bits
    localparam int TXC_CLOCKED     = 4; // clocked_mode_select
    localparam int TXC_TX_EN       = 5; // transmit_enable
    localparam int TXC_NINE_EN     = 6; // nine_bit_transmit_enable
    localparam logic [7:0] TXC_RESET     = 8'h02;
    localparam logic [7:0] TXC_WR_MASK   = 8'hfd;

    // receive_control_register fields
    localparam int RXC_RX_EN     = 4; // receive_enable
    localparam int RXC_PORT_EN   = 7; // serial_port_enable

    // interrupt_control_register fields
    localparam int INT_TX_IE     = 0; // transmit_interrupt_enable
    localparam int INT_TX_FLAG   = 1; // transmit_buffer_empty_flag (read only)
    localparam int INT_PERIPH_IE = 2; // peripheral_interrupt_enable
    localparam int INT_GLOBAL_IE = 3; // global_interrupt_enable
    localparam logic [7:0] INT_WR_MASK = 8'h0d;

    // pin direction fields
    localparam int DIR_TX = 0;
    localparam int DIR_RX = 1;
    localparam logic [1:0] DIR_RESET = 2'h3;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_MHZ         = 200;
    localparam int INSTR_NS        = 20;  // instruction_cycle length
    localparam int CLK_NS          = 1000 / CLK_MHZ;
    localparam int INSTR_CYCLES    = (INSTR_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] INSTR_LAST = 4'(INSTR_CYCLES - 1);
    localparam logic [15:0] BAUD_RESET = 16'h0000;
    localparam logic [3:0] DATA_BITS_8 = 4'h8;
    localparam logic [3:0] DATA_BITS_9 = 4'h9;
    localparam logic [1:0] STOP_ONE    = 2'h1;
    localparam logic [1:0] STOP_TWO    = 2'h2;
    localparam logic [1:0] FLAG_DELAY  = 2'h2; // instruction periods before flag clears

    typedef enum logic [1:0] {
        UAT_IDLE,
        UAT_START,
        UAT_DATA,
        UAT_STOP
    } uat_state_t;
endpackage

// ---- rtl/uat_tx.sv ----
`timescale 1ns/1ps
module uat_tx
    import uat_pkg::*;
(
    input  wire logic        clk,          // system clock
    input  wire logic        reset_n,      // async reset, active low
    input  wire logic        psel,         // apb select
    input  wire logic        penable,      // apb access phase
    input  wire logic        pwrite,       // apb direction
    input  wire logic [7:0]  paddr,        // apb byte address
    input  wire logic [31:0] pwdata,       // apb write data
    output logic      [31:0] prdata,       // apb read data
    output logic             pready,       // apb ready
    output logic             pslverr,      // apb error
    output logic             tx_out,       // transmit_pin output level
    output logic             tx_oe,        // transmit_pin output enable
    input  wire logic        rx_in,        // receive_pin input level
    output logic             rx_oe,        // receive_pin output enable
    output logic             tx_irq        // transmit interrupt request
);
    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------
    function automatic logic is_mapped(input logic [7:0] a);
        return a == ADDR_TX_CTRL || a == ADDR_RX_CTRL || a == ADDR_TX_BUF ||
               a == ADDR_BAUD_LO || a == ADDR_BAUD_HI || a == ADDR_INT_CTRL ||
               a == ADDR_PIN_DIR;
    endfunction

    logic        access;
    logic        wr_en;
    logic [7:0]  txc_q;
    logic [7:0]  rxc_q;
    logic [15:0] baud_q;
    logic [7:0]  intc_q;
    logic [1:0]  dir_q;
    logic [8:0]  buf_q;
    logic        pend_q;
    logic [8:0]  shf_q;
    logic [3:0]  bitn_q;
    logic [1:0]  stopn_q;
    logic [15:0] bcnt_q;
    uat_state_t  st_q;
    logic [3:0]  icnt_q;
    logic        gap_q;
    logic [1:0]  fdly_q;
    logic        flag_vis_q;
    logic        tx_active;
    logic        tick;
    logic        load;
    logic        shift_empty;
    logic        flag_true;
    logic        buf_wr;

    assign access  = psel && penable;
    assign wr_en   = access && pwrite;
    assign pready  = 1'b1;
    assign pslverr = access && !is_mapped(paddr);
    assign buf_wr  = wr_en && paddr == ADDR_TX_BUF;

    // asynchronous transmit qualification
    assign tx_active = txc_q[TXC_TX_EN] && rxc_q[RXC_PORT_EN] &&
                       !txc_q[TXC_CLOCKED];

    // pin direction overrides
    assign tx_oe = (tx_active) ? 1'b1 : !dir_q[DIR_TX];
    assign rx_oe = (rxc_q[RXC_PORT_EN] && rxc_q[RXC_RX_EN] && !txc_q[TXC_CLOCKED]) ?
                   1'b0 : !dir_q[DIR_RX];

    // ---------------------------------------------------------------
    // control registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            txc_q  <= TXC_RESET;
            rxc_q  <= 8'h00;
            baud_q <= BAUD_RESET;
            intc_q <= 8'h00;
            dir_q  <= DIR_RESET;
        end else if (wr_en) begin
            // read-only bits never written
            case (paddr)
                ADDR_TX_CTRL:  txc_q <= pwdata[7:0] & TXC_WR_MASK;
                ADDR_RX_CTRL:  rxc_q <= pwdata[7:0];
                ADDR_BAUD_LO:  baud_q[7:0] <= pwdata[7:0];
                ADDR_BAUD_HI:  baud_q[15:8] <= pwdata[7:0];
                ADDR_INT_CTRL: intc_q <= pwdata[7:0] & INT_WR_MASK;
                ADDR_PIN_DIR:  dir_q <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // read mux; shift register itself has no address
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                ADDR_TX_CTRL: begin
                    prdata <= {24'h00_0000, txc_q};
                    prdata[TXC_SHIFT_EMPTY] <= shift_empty;
                end
                ADDR_RX_CTRL:  prdata <= {24'h00_0000, rxc_q};
                ADDR_BAUD_LO:  prdata <= {24'h00_0000, baud_q[7:0]};
                ADDR_BAUD_HI:  prdata <= {24'h00_0000, baud_q[15:8]};
                ADDR_INT_CTRL: begin
                    prdata <= {24'h00_0000, intc_q};
                    prdata[INT_TX_FLAG] <= flag_vis_q;
                end
                ADDR_PIN_DIR:  prdata <= {30'h0000_0000, dir_q};
                default:       prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // instruction cycle strobe
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            icnt_q <= 4'h0;
        end else begin
            icnt_q <= (icnt_q == INSTR_LAST) ? 4'h0 : icnt_q + 4'h1;
        end
    end

    // ---------------------------------------------------------------
    // baud generator: one tick per (divisor + 1) clocks, shared format
    // ---------------------------------------------------------------
    assign tick = (bcnt_q == baud_q);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bcnt_q <= 16'h0000;
        end else if (st_q == UAT_IDLE || tick) begin
            bcnt_q <= 16'h0000;
        end else begin
            bcnt_q <= bcnt_q + 16'h0001;
        end
    end

    // ---------------------------------------------------------------
    // holding buffer; ninth bit captured with the low byte write
    // ---------------------------------------------------------------
    assign shift_empty = (st_q == UAT_IDLE);
    assign load = pend_q && shift_empty && !gap_q && tx_active;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            buf_q  <= 9'h000;
            pend_q <= 1'b0;
        end else if (buf_wr) begin
            buf_q  <= {txc_q[TXC_NINTH_BIT], pwdata[7:0]};
            pend_q <= 1'b1;
        end else if (load) begin
            pend_q <= 1'b0;
        end
    end

    // one instruction cycle gap after a stop bit before the next load
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gap_q <= 1'b0;
        end else if (st_q == UAT_STOP && tick && stopn_q == STOP_ONE) begin
            gap_q <= 1'b1;
        end else if (icnt_q == INSTR_LAST) begin
            gap_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // frame state machine
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q    <= UAT_IDLE;
            shf_q   <= 9'h000;
            bitn_q  <= 4'h0;
            stopn_q <= 2'h0;
            tx_out  <= 1'b1;
        end else begin
            case (st_q)
                UAT_IDLE: begin
                    tx_out <= 1'b1;
                    if (load) begin
                        shf_q  <= buf_q;
                        bitn_q <= txc_q[TXC_NINE_EN] ? DATA_BITS_9 : DATA_BITS_8;
                        stopn_q <= txc_q[TXC_STOP2] ? STOP_TWO : STOP_ONE;
                        tx_out <= 1'b0;
                        st_q   <= UAT_START;
                    end
                end
                UAT_START: if (tick) begin
                    tx_out <= shf_q[0];
                    shf_q  <= {1'b0, shf_q[8:1]};
                    bitn_q <= bitn_q - 4'h1;
                    st_q   <= UAT_DATA;
                end
                UAT_DATA: if (tick) begin
                    if (bitn_q == 4'h0) begin
                        tx_out <= 1'b1;
                        st_q   <= UAT_STOP;
                    end else begin
                        tx_out <= shf_q[0];
                        shf_q  <= {1'b0, shf_q[8:1]};
                        bitn_q <= bitn_q - 4'h1;
                    end
                end
                UAT_STOP: if (tick) begin
                    if (stopn_q == STOP_ONE) begin
                        st_q <= UAT_IDLE;
                    end
                    stopn_q <= stopn_q - 2'h1;
                end
                default: st_q <= UAT_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // buffer empty flag, its clear delayed two instruction periods
    // ---------------------------------------------------------------
    assign flag_true = tx_active && !(pend_q && !load);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fdly_q     <= 2'h0;
            flag_vis_q <= 1'b0;
        end else begin
            if (buf_wr) begin
                fdly_q <= FLAG_DELAY;
            end else if (fdly_q != 2'h0 && icnt_q == INSTR_LAST) begin
                fdly_q <= fdly_q - 2'h1;
            end
            if (flag_true) begin
                flag_vis_q <= 1'b1;
            end else if (fdly_q == 2'h0 && !buf_wr) begin
                flag_vis_q <= 1'b0;
            end
        end
    end

    assign tx_irq = flag_vis_q && intc_q[INT_TX_IE] && intc_q[INT_PERIPH_IE] &&
                    intc_q[INT_GLOBAL_IE];

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_idle_mark: assert property (@(posedge clk) disable iff (!reset_n)
        st_q == UAT_IDLE && $past(st_q) == UAT_IDLE |-> tx_out)
        else $error("line not at mark while idle");
    a_start_space: assert property (@(posedge clk) disable iff (!reset_n)
        st_q == UAT_START |-> !tx_out)
        else $error("start bit not zero");
    a_stop_mark: assert property (@(posedge clk) disable iff (!reset_n)
        st_q == UAT_STOP |-> tx_out)
        else $error("stop bit not one");
    a_load_now: assert property (@(posedge clk) disable iff (!reset_n)
        load |=> st_q == UAT_START)
        else $error("load did not start frame");
    a_oe_forced: assert property (@(posedge clk) disable iff (!reset_n)
        tx_active |-> tx_oe)
        else $error("transmit pin not output");
    a_irq_gate: assert property (@(posedge clk) disable iff (!reset_n)
        tx_irq |-> flag_vis_q && intc_q[INT_GLOBAL_IE])
        else $error("irq without flag");
    a_flag_hold: assert property (@(posedge clk) disable iff (!reset_n)
        buf_wr && flag_vis_q |=> flag_vis_q)
        else $error("flag cleared too early");
    a_no_send_off: assert property (@(posedge clk) disable iff (!reset_n)
        !tx_active |-> !load)
        else $error("load while disabled");

    // ---------------------------------------------------------------
    // frame timing and bit order checks
    // ---------------------------------------------------------------
    // the bit counter never runs past the programmed divisor
    a_baud_bound: assert property (@(posedge clk) disable iff (!reset_n)
        st_q != UAT_IDLE |-> bcnt_q <= baud_q)
        else $error("bit counter beyond divisor");
    // first data bit on the line is the low bit of the shifter
    a_data_lsb: assert property (@(posedge clk) disable iff (!reset_n)
        st_q == UAT_START && tick |=> tx_out == $past(shf_q[0]))
        else $error("first data bit not least significant");
    // nine-bit mode loads a nine bit count
    a_nine_len: assert property (@(posedge clk) disable iff (!reset_n)
        load && txc_q[TXC_NINE_EN] |=> bitn_q == DATA_BITS_9)
        else $error("nine-bit frame length wrong");
    // ninth bit captured from the control register at the buffer write
    a_ninth_cap: assert property (@(posedge clk) disable iff (!reset_n)
        buf_wr |=> buf_q[8] == $past(txc_q[TXC_NINTH_BIT]))
        else $error("ninth bit not captured");

    // ---------------------------------------------------------------
    // shift status and queueing checks
    // ---------------------------------------------------------------
    // a load marks the shifter busy on the next cycle
    a_load_busy: assert property (@(posedge clk) disable iff (!reset_n)
        load |=> !shift_empty)
        else $error("shift empty while loaded");
    // the last stop bit returns the shifter to empty
    a_stop_empty: assert property (@(posedge clk) disable iff (!reset_n)
        st_q == UAT_STOP && tick && stopn_q == STOP_ONE |=> shift_empty)
        else $error("shifter not empty after stop");
    // no load straight after a stop bit: the gap comes first
    a_stop_gap: assert property (@(posedge clk) disable iff (!reset_n)
        st_q == UAT_STOP && tick && stopn_q == STOP_ONE |=> !load)
        else $error("load without gap after stop");

    // ---------------------------------------------------------------
    // flag, interrupt and pin checks
    // ---------------------------------------------------------------
    // enabled with nothing pending sets the flag
    a_flag_set: assert property (@(posedge clk) disable iff (!reset_n)
        tx_active && !pend_q |=> flag_vis_q)
        else $error("flag not set while empty");
    // busy shifter with a queued character clears the settled flag
    a_flag_queued: assert property (@(posedge clk) disable iff (!reset_n)
        tx_active && pend_q && !shift_empty && fdly_q == 2'h0 && !buf_wr
        |=> !flag_vis_q)
        else $error("flag set while character queued");
    // all four conditions true raise the request
    a_irq_all: assert property (@(posedge clk) disable iff (!reset_n)
        flag_vis_q && intc_q[INT_TX_IE] && intc_q[INT_PERIPH_IE] &&
        intc_q[INT_GLOBAL_IE] |-> tx_irq)
        else $error("irq missing");
    // receive pin forced to input when receive is enabled asynchronous
    a_rx_input: assert property (@(posedge clk) disable iff (!reset_n)
        rxc_q[RXC_PORT_EN] && rxc_q[RXC_RX_EN] && !txc_q[TXC_CLOCKED] |-> !rx_oe)
        else $error("receive pin driven");

    // main scenarios reached
    c_nine: cover property (@(posedge clk) disable iff (!reset_n)
        load && txc_q[TXC_NINE_EN]);
    c_two_stop: cover property (@(posedge clk) disable iff (!reset_n)
        load && txc_q[TXC_STOP2]);
    c_frame: cover property (@(posedge clk) disable iff (!reset_n)
        st_q == UAT_STOP ##1 st_q == UAT_IDLE);
    c_back: cover property (@(posedge clk) disable iff (!reset_n)
        buf_wr && !shift_empty);
    c_irq: cover property (@(posedge clk) disable iff (!reset_n) $rose(tx_irq));
endmodule

// ---- dv/uat_term_model.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// remote terminal: decodes frames seen on the transmit line
// ---------------------------------------------------------------
module uat_term_model (
    input  wire logic        clk,       // system clock
    input  wire logic        reset_n,   // async reset, active low
    input  wire logic        line,      // transmit line from the block
    input  wire logic        nine,      // nine data bits per frame
    input  wire logic [15:0] bit_clks,  // clocks per bit
    output logic             rx_line,   // terminal's own line
    output logic      [8:0]  char_q,    // last character received
    output logic      [7:0]  frames_q,  // frames received so far
    output logic      [15:0] start_len, // clocks from fall to first high
    output logic      [15:0] idle_len,  // high run before the last start
    output logic             stop_ok    // start was space, stop was mark
);
    logic [10:0] smp;
    int          n;
    int          hi;
    int          st;

    // terminal stays silent, its own line rests at mark
    assign rx_line = 1'b1;

    // sample each bit at its centre, counted from the falling edge
    initial begin
        frames_q = 8'h00;
        hi = 0;
        forever begin
            @(negedge clk);
            if (reset_n !== 1'b1 || line !== 1'b0) begin
                hi++;
            end else begin
                idle_len = 16'(hi);
                n = nine ? 9 : 8;
                st = 0;
                for (int t = 1; t <= (n + 1) * bit_clks + bit_clks / 2; t++) begin
                    @(negedge clk);
                    if (line === 1'b1 && st == 0) st = t;
                    if (t % bit_clks == bit_clks / 2) smp[t / bit_clks] = line;
                end
                start_len = 16'(st);
                for (int i = 0; i < 9; i++) char_q[i] = (i < n) ? smp[i + 1] : 1'b0;
                stop_ok = smp[0] === 1'b0 && smp[n + 1] === 1'b1;
                hi = bit_clks / 2 + 1;
                frames_q++;
            end
        end
    end
endmodule

// ---- dv/uat_tx_tb.sv ----
`timescale 1ns/1ps
module uat_tx_tb
    import uat_pkg::*;
;
    localparam int DIV = 7;
    localparam int BIT = DIV + 1;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, r;
    logic        pready, pslverr, tx_out, tx_oe, rx_in, rx_oe, tx_irq, e, stop_ok;
    logic        nine = 1'b0;
    logic [8:0]  char_q;
    logic [7:0]  frames;
    logic [15:0] start_len, idle_len;
    int          errors = 0;
    int          checked = 0;

    always #2.5 clk = ~clk;

    uat_tx dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_out(tx_out), .tx_oe(tx_oe),
        .rx_in(rx_in), .rx_oe(rx_oe), .tx_irq(tx_irq));
    uat_term_model term (.clk(clk), .reset_n(reset_n), .line(tx_out), .nine(nine),
        .bit_clks(16'(BIT)), .rx_line(rx_in), .char_q(char_q), .frames_q(frames),
        .start_len(start_len), .idle_len(idle_len), .stop_ok(stop_ok));

    // ---------------------------------------------------------------
    // compare, bus and closing tasks
    // ---------------------------------------------------------------
    task automatic chk_bit(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer: setup cycle, then access until pready
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] rd_q, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd_q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic        y;
        apb(a, 1'b1, d, x, y);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(a, 1'b0, 32'h0, r, e);
    endtask
    task automatic wait_frames(input int n);
        for (int i = 0; i < 4000 && frames !== 8'(n); i++) @(posedge clk);
        chk_word("frames", 32'(n), {24'h0, frames});
    endtask
    task automatic final_report();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        rd(ADDR_TX_CTRL);
        chk_word("tx ctrl reset", {24'h0, TXC_RESET}, r);
        chk_bit("idle line", 1'b1, tx_out);
        apb(8'h1c, 1'b0, 32'h0, r, e);
        chk_bit("unmapped err", 1'b1, e);
        chk_word("unmapped data", 32'h0, r);
    endtask
    // pins forced by enables against opposite direction bits
    task automatic t_pins();
        wr(ADDR_BAUD_LO, 32'(DIV));
        wr(ADDR_BAUD_HI, 32'h0);
        wr(ADDR_PIN_DIR, 32'h1);
        wr(ADDR_RX_CTRL, 32'h90);
        wr(ADDR_TX_CTRL, 32'h20);
        @(negedge clk);
        chk_bit("tx pin drives", 1'b1, tx_oe);
        chk_bit("rx pin input", 1'b0, rx_oe);
        chk_bit("idle enabled", 1'b1, tx_out);
    endtask
    task automatic t_flag_irq();
        rd(ADDR_INT_CTRL);
        chk_bit("flag empty", 1'b1, r[INT_TX_FLAG]);
        wr(ADDR_INT_CTRL, 32'h0d);
        @(negedge clk);
        chk_bit("irq on enable", 1'b1, tx_irq);
        wr(ADDR_INT_CTRL, 32'h0);
        rd(ADDR_INT_CTRL);
        chk_bit("flag kept", 1'b1, r[INT_TX_FLAG]);
        chk_bit("irq masked", 1'b0, tx_irq);
        wr(ADDR_INT_CTRL, 32'h0d);
    endtask
    task automatic t_single();
        int t;
        wr(ADDR_TX_BUF, 32'ha5);
        for (t = 0; t < 8 && tx_out !== 1'b0; t++) @(negedge clk);
        chk_bit("start at once", 1'b1, t <= 2);
        rd(ADDR_TX_CTRL);
        chk_bit("shift busy", 1'b0, r[TXC_SHIFT_EMPTY]);
        wait_frames(1);
        chk_word("char a5", 32'h0a5, {23'h0, char_q});
        chk_bit("start stop", 1'b1, stop_ok);
        chk_word("start len", 32'(BIT), {16'h0, start_len});
        // let the stop bit finish before looking at the shift status
        repeat (BIT) @(posedge clk);
        rd(ADDR_TX_CTRL);
        chk_bit("shift empty", 1'b1, r[TXC_SHIFT_EMPTY]);
    endtask
    // second character queued behind a busy shift register
    task automatic t_b2b();
        wr(ADDR_TX_BUF, 32'h11);
        wr(ADDR_TX_BUF, 32'h22);
        rd(ADDR_INT_CTRL);
        chk_bit("flag stale", 1'b1, r[INT_TX_FLAG]);
        repeat (12) @(posedge clk);
        rd(ADDR_INT_CTRL);
        chk_bit("flag queued", 1'b0, r[INT_TX_FLAG]);
        chk_bit("irq queued", 1'b0, tx_irq);
        wr(ADDR_INT_CTRL, 32'h0f);
        rd(ADDR_INT_CTRL);
        chk_bit("flag not set", 1'b0, r[INT_TX_FLAG]);
        wait_frames(2);
        chk_word("char 11", 32'h011, {23'h0, char_q});
        wait_frames(3);
        chk_word("char 22", 32'h022, {23'h0, char_q});
        chk_bit("one stop gap", 1'b1, idle_len >= BIT && idle_len <= BIT + INSTR_CYCLES + 2);
        @(negedge clk);
        chk_bit("irq drained", 1'b1, tx_irq);
    endtask
    task automatic t_nine();
        nine <= 1'b1;
        wr(ADDR_TX_CTRL, 32'h61);
        wr(ADDR_TX_BUF, 32'h3c);
        wait_frames(4);
        chk_word("nine addr", 32'h13c, {23'h0, char_q});
        wr(ADDR_TX_CTRL, 32'h60);
        wr(ADDR_TX_BUF, 32'hff);
        wait_frames(5);
        chk_word("nine data", 32'h0ff, {23'h0, char_q});
        // two stop bits, eight data bits, second character queued
        nine <= 1'b0;
        wr(ADDR_TX_CTRL, 32'h24);
        wr(ADDR_TX_BUF, 32'h81);
        wr(ADDR_TX_BUF, 32'h42);
        wait_frames(6);
        chk_word("char 81", 32'h081, {23'h0, char_q});
        wait_frames(7);
        chk_word("char 42", 32'h042, {23'h0, char_q});
        chk_bit("two stop gap", 1'b1, idle_len >= 2 * BIT && idle_len <= 2 * BIT + INSTR_CYCLES + 2);
    endtask
    task automatic t_clocked();
        wr(ADDR_TX_CTRL, 32'h30);
        wr(ADDR_TX_BUF, 32'h55);
        repeat (12 * BIT) @(posedge clk);
        chk_word("no frame", 32'h7, {24'h0, frames});
        chk_bit("pin released", 1'b0, tx_oe);
        chk_bit("line mark", 1'b1, tx_out);
    endtask

    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_pins();
        t_flag_irq();
        t_single();
        t_b2b();
        t_nine();
        t_clocked();
        final_report();
    end
    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        final_report();
    end
endmodule
